// ===== verilog/energy_cal_pkg.sv
//------------------------------------------------------------------------------
// Purpose: shared constants of the energy gain and pulse calibration block
// Assumes: 32-bit AHB-Lite register bus, 10 MHz clock
// Notes:   offsets are byte addresses of aligned words
//------------------------------------------------------------------------------
package energy_cal_pkg;
  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL      = 8'h00;
  localparam logic [7:0] OFS_FINE_GAIN    = 8'h04;
  localparam logic [7:0] OFS_ENERGY_DIV   = 8'h08;
  localparam logic [7:0] OFS_PULSE_NUM    = 8'h0C;
  localparam logic [7:0] OFS_PULSE_DEN    = 8'h10;
  localparam logic [7:0] OFS_HALF_CYCLES  = 8'h14;
  localparam logic [7:0] OFS_ACCUM_ACTIVE = 8'h18;
  localparam logic [7:0] OFS_LINE_ACTIVE  = 8'h1C;
  localparam logic [7:0] OFS_LINE_APPAR   = 8'h20;
  localparam logic [7:0] OFS_LINE_PERIOD  = 8'h24;
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK     = 8'h2C;
  // ---------------------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------------------
  localparam int          BIT_LINE_MODE   = 0;
  localparam int          BIT_IRQ_LINE    = 0;
  localparam int          BIT_IRQ_PULSE   = 1;
  localparam int          IRQ_BITS        = 2;
  localparam logic [11:0] RST_PULSE_NUM   = 12'h03F;
  localparam logic [11:0] RST_PULSE_DEN   = 12'h03F;
  localparam logic [15:0] RST_HALF_CYCLES = 16'hFFFF;
  // ---------------------------------------------------------------------------
  // arithmetic and timing
  // ---------------------------------------------------------------------------
  localparam int          GAIN_SHIFT      = 12;   // gain step is 1/2^12
  localparam logic [13:0] GAIN_UNITY      = 14'h1000;
  localparam int          FRAC_BITS       = 16;   // sample fraction below lsb
  localparam int          PERIOD_PRESCALE = 8;    // period lsb in clocks
  localparam int          CLOCK_HZ        = 10_000_000;
  localparam int          PULSE_WIDTH_NS  = 1000;
  localparam int          PULSE_CYCLES    =
    (PULSE_WIDTH_NS * (CLOCK_HZ / 1_000_000)) / 1000;
endpackage : energy_cal_pkg

// ===== verilog/pulse_link_if.sv
//------------------------------------------------------------------------------
// Purpose: energy tick path from the accumulator to the pulse scaler
// Assumes: single clock domain
// Notes:   tick is one cycle per raw energy unit of either sign
//------------------------------------------------------------------------------
`timescale 1ns/100ps
interface pulse_link_if;
  logic        tick;       // one raw energy unit passed
  logic [11:0] numerator;  // pulse numerator setting
  logic [11:0] denominator;// pulse denominator setting
  logic        pulse;      // calibration pulse level
  logic        pulse_event;// one-cycle start of a pulse
  modport source (output tick, output numerator, output denominator,
                  input pulse, input pulse_event);
  modport scaler (input tick, input numerator, input denominator,
                  output pulse, output pulse_event);
endinterface : pulse_link_if

// ===== verilog/pulse_scaler.sv
//------------------------------------------------------------------------------
// Purpose: scale energy ticks by (numerator+1)/(denominator+1) into pulses
// Assumes: ticks come no faster than one per four clocks
// Notes:   pulse is stretched to a fixed width
//------------------------------------------------------------------------------
`timescale 1ns/100ps
module pulse_scaler
  import energy_cal_pkg::*;
(
  input  wire logic clock,
  input  wire logic sys_rst,
  pulse_link_if.scaler lnk
);
  logic [12:0] acc_q;
  logic [12:0] num_p1;
  logic [12:0] den_p1;
  logic [12:0] sum;
  logic        fire;
  logic [15:0] width_q;

  // fractional rate accumulator
  assign num_p1 = {1'b0, lnk.numerator} + 13'h0001;
  assign den_p1 = {1'b0, lnk.denominator} + 13'h0001;
  assign sum    = lnk.tick ? acc_q + num_p1 : acc_q;
  assign fire   = sum >= den_p1;

  // remainder is carried so the long-run rate is exact
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      acc_q <= 13'h0000;
    end else if (fire) begin
      acc_q <= sum - den_p1;
    end else begin
      acc_q <= sum;
    end
  end

  // stretch each pulse, retrigger extends it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      width_q         <= 16'h0000;
      lnk.pulse       <= 1'b0;
      lnk.pulse_event <= 1'b0;
    end else begin
      lnk.pulse_event <= fire;
      if (fire) begin
        width_q   <= 16'(PULSE_CYCLES);
        lnk.pulse <= 1'b1;
      end else if (width_q > 16'h0001) begin
        width_q <= width_q - 16'h0001;
      end else begin
        width_q   <= 16'h0000;
        lnk.pulse <= 1'b0;
      end
    end
  end
endmodule : pulse_scaler

// ===== verilog/line_cycle_energy_gain_cal.sv
//------------------------------------------------------------------------------
// Purpose: fine gain, energy divider, pulse scaling, line-cycle accumulation
// Assumes: power samples arrive at most one per four clocks, magnitude below
//          two thirds of 2^FRAC_BITS; half_cycle_mark pulses at zero crossings
// Notes:   registers over AHB-Lite, zero wait state, OKAY response only
//------------------------------------------------------------------------------
//
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
// Operation
// - one gain count moves energy and pulse rate by 0.0244 percent.
// - fine gain is signed twos complement, covering plus minus 50 percent.
// - after programmed half cycles, interrupt goes low and line energy readable.
// - first accumulation may be short; host discards it, later ones valid.
// - pulse rate scaled by numerator plus one over denominator plus one.
// - energy divider scales accumulated energy only, never the pulse output.
// - pulse and energy scale by one plus gain over 2 to the 12.
// - line period counts in units of eight clock periods.
module line_cycle_energy_gain_cal
  import energy_cal_pkg::*;
#(
  parameter int SAMPLE_W = 16
) (
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  input  wire logic                sample_valid,
  input  wire logic signed [SAMPLE_W-1:0] active_sample,
  input  wire logic [SAMPLE_W-1:0] apparent_sample,
  input  wire logic                half_cycle_mark,
  output logic                     calibration_pulse_out,
  output logic                     irq_n,
  output logic                     irq_oe
);
  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  logic                 line_mode_q;
  logic [11:0]          active_fine_gain_q;
  logic [7:0]           energy_divider_q;
  logic [15:0]          half_cycle_count_q;
  logic [IRQ_BITS-1:0]  irq_status_q;
  logic [IRQ_BITS-1:0]  irq_mask_q;
  logic [IRQ_BITS-1:0]  irq_set;
  logic                 wr_pend_q;
  logic [7:0]           wr_addr_q;
  logic                 take;
  logic [31:0]          rd_mux;
  logic signed [13:0]   gain_factor;
  logic signed [31:0]   gained;
  logic signed [31:0]   frac_sum;
  logic signed [31:0]   frac_q;
  logic                 up_tick;
  logic                 dn_tick;
  logic signed [8:0]    div_cnt_q;
  logic signed [8:0]    div_lim;
  logic                 e_up;
  logic                 e_dn;
  logic signed [23:0]   accumulated_active_energy_q;
  logic signed [23:0]   line_active_run_q;
  logic signed [23:0]   line_cycle_active_energy_q;
  logic [39:0]          line_appar_run_q;
  logic [23:0]          line_cycle_apparent_energy_q;
  logic [15:0]          half_seen_q;
  logic                 interval_end;
  logic [2:0]           presc_q;
  logic [15:0]          period_run_q;
  logic [15:0]          line_period_q;
  logic                 parity_q;
  pulse_link_if         lnk ();

  // ---------------------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------------------
  assign take = hsel & htrans[1] & hready;

  // read mux, captured in the address phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      OFS_CONTROL:      rd_mux[BIT_LINE_MODE] = line_mode_q;
      OFS_FINE_GAIN:    rd_mux = {{20{active_fine_gain_q[11]}},
                                  active_fine_gain_q};
      OFS_ENERGY_DIV:   rd_mux[7:0] = energy_divider_q;
      OFS_PULSE_NUM:    rd_mux[11:0] = lnk.numerator;
      OFS_PULSE_DEN:    rd_mux[11:0] = lnk.denominator;
      OFS_HALF_CYCLES:  rd_mux[15:0] = half_cycle_count_q;
      OFS_ACCUM_ACTIVE: rd_mux = {{8{accumulated_active_energy_q[23]}},
                                  accumulated_active_energy_q};
      OFS_LINE_ACTIVE:  rd_mux = {{8{line_cycle_active_energy_q[23]}},
                                  line_cycle_active_energy_q};
      OFS_LINE_APPAR:   rd_mux[23:0] = line_cycle_apparent_energy_q;
      OFS_LINE_PERIOD:  rd_mux[15:0] = line_period_q;
      OFS_IRQ_STATUS:   rd_mux[IRQ_BITS-1:0] = irq_status_q;
      OFS_IRQ_MASK:     rd_mux[IRQ_BITS-1:0] = irq_mask_q;
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // address phase capture and response
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= take & hwrite;
      if (take) begin
        wr_addr_q <= haddr[7:0];
      end
      if (take & ~hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // control registers written in the data phase
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      line_mode_q        <= 1'b0;
      active_fine_gain_q <= 12'h000;
      energy_divider_q   <= 8'h00;
      lnk.numerator      <= RST_PULSE_NUM;
      lnk.denominator    <= RST_PULSE_DEN;
      half_cycle_count_q <= RST_HALF_CYCLES;
      irq_mask_q         <= '0;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        OFS_CONTROL:     line_mode_q        <= hwdata[BIT_LINE_MODE];
        OFS_FINE_GAIN:   active_fine_gain_q <= hwdata[11:0];
        OFS_ENERGY_DIV:  energy_divider_q   <= hwdata[7:0];
        OFS_PULSE_NUM:   lnk.numerator      <= hwdata[11:0];
        OFS_PULSE_DEN:   lnk.denominator    <= hwdata[11:0];
        OFS_HALF_CYCLES: half_cycle_count_q <= hwdata[15:0];
        OFS_IRQ_MASK:    irq_mask_q         <= hwdata[IRQ_BITS-1:0];
        default:         ;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------------------
  assign irq_set[BIT_IRQ_LINE]  = interval_end;
  assign irq_set[BIT_IRQ_PULSE] = lnk.pulse_event;

  // sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_status_q <= '0;
    end else if (wr_pend_q && wr_addr_q == OFS_IRQ_STATUS) begin
      irq_status_q <= (irq_status_q & ~hwdata[IRQ_BITS-1:0]) | irq_set;
    end else begin
      irq_status_q <= irq_status_q | irq_set;
    end
  end

  // open-drain request line, pulled low while an unmasked bit is set
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_n  <= 1'b1;
      irq_oe <= 1'b0;
    end else begin
      irq_n  <= ~|(irq_status_q & irq_mask_q);
      irq_oe <= |(irq_status_q & irq_mask_q);
    end
  end

  // ---------------------------------------------------------------------------
  // gain and raw energy ticks
  // ---------------------------------------------------------------------------
  // factor 4096+gain, signed 12-bit gain gives 2048..6143, i.e. 0.5x..1.5x
  assign gain_factor = $signed(GAIN_UNITY)
                     + $signed({{2{active_fine_gain_q[11]}},
                                active_fine_gain_q});
  assign gained   = sample_valid ? (32'(active_sample) * 32'(gain_factor))
                                   >>> GAIN_SHIFT : 32'sd0;
  assign frac_sum = frac_q + gained;
  assign up_tick  = frac_sum >=  $signed(32'(1 << FRAC_BITS));
  assign dn_tick  = frac_sum <= -$signed(32'(1 << FRAC_BITS));

  // fractional energy, at most one unit per sample
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      frac_q <= 32'sd0;
    end else if (up_tick) begin
      frac_q <= frac_sum - $signed(32'(1 << FRAC_BITS));
    end else if (dn_tick) begin
      frac_q <= frac_sum + $signed(32'(1 << FRAC_BITS));
    end else begin
      frac_q <= frac_sum;
    end
  end

  // pulse path takes raw ticks, bypassing the energy divider
  assign lnk.tick = up_tick | dn_tick;

  pulse_scaler u_scaler (
    .clock   (clock),
    .sys_rst (sys_rst),
    .lnk     (lnk)
  );

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      calibration_pulse_out <= 1'b0;
    end else begin
      calibration_pulse_out <= lnk.pulse;
    end
  end

  // ---------------------------------------------------------------------------
  // energy divider, divider 0 behaves as 1
  // ---------------------------------------------------------------------------
  assign div_lim = (energy_divider_q == 8'h00)
                 ? 9'sd1 : $signed({1'b0, energy_divider_q});
  assign e_up    = up_tick && (div_cnt_q + 9'sd1 >= div_lim);
  assign e_dn    = dn_tick && (div_cnt_q - 9'sd1 <= -div_lim);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_cnt_q <= 9'sd0;
    end else if (e_up || e_dn) begin
      div_cnt_q <= 9'sd0;
    end else if (up_tick) begin
      div_cnt_q <= div_cnt_q + 9'sd1;
    end else if (dn_tick) begin
      div_cnt_q <= div_cnt_q - 9'sd1;
    end
  end

  // running accumulated energy, wraps on overflow
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      accumulated_active_energy_q <= 24'sd0;
    end else if (e_up) begin
      accumulated_active_energy_q <= accumulated_active_energy_q + 24'sd1;
    end else if (e_dn) begin
      accumulated_active_energy_q <= accumulated_active_energy_q - 24'sd1;
    end
  end

  // ---------------------------------------------------------------------------
  // line period and line-cycle accumulation
  // ---------------------------------------------------------------------------
  // period counted in eight-clock units between every second half-cycle mark
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      presc_q       <= 3'd0;
      period_run_q  <= 16'h0000;
      line_period_q <= 16'h0000;
      parity_q      <= 1'b0;
    end else begin
      presc_q <= presc_q + 3'd1;
      if (half_cycle_mark) begin
        parity_q <= ~parity_q;
      end
      if (half_cycle_mark && parity_q) begin
        line_period_q <= period_run_q;
        period_run_q  <= 16'h0000;
      end else if (presc_q == 3'(PERIOD_PRESCALE - 1)
                   && period_run_q != 16'hFFFF) begin
        period_run_q <= period_run_q + 16'h0001;
      end
    end
  end

  // counter is held at zero until line mode is set, which may fall mid half cycle, so the first interval may be short
  assign interval_end = line_mode_q && half_cycle_mark
                        && (half_seen_q + 16'h0001 >= half_cycle_count_q);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      half_seen_q <= 16'h0000;
    end else if (!line_mode_q || interval_end) begin
      half_seen_q <= 16'h0000;
    end else if (half_cycle_mark) begin
      half_seen_q <= half_seen_q + 16'h0001;
    end
  end

  // line energies latch at interval end and restart from zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      line_active_run_q            <= 24'sd0;
      line_cycle_active_energy_q   <= 24'sd0;
      line_appar_run_q             <= 40'h00_0000_0000;
      line_cycle_apparent_energy_q <= 24'h00_0000;
    end else if (interval_end) begin
      line_cycle_active_energy_q   <= line_active_run_q
                                      + (e_up ? 24'sd1 : 24'sd0)
                                      - (e_dn ? 24'sd1 : 24'sd0);
      line_cycle_apparent_energy_q <= line_appar_run_q[FRAC_BITS +: 24];
      line_active_run_q            <= 24'sd0;
      line_appar_run_q             <= 40'h00_0000_0000;
    end else begin
      if (e_up) begin
        line_active_run_q <= line_active_run_q + 24'sd1;
      end else if (e_dn) begin
        line_active_run_q <= line_active_run_q - 24'sd1;
      end
      if (sample_valid) begin
        line_appar_run_q <= line_appar_run_q + 40'(apparent_sample);
      end
    end
  end
endmodule : line_cycle_energy_gain_cal

// ===== sim/line_cycle_checker.sv
// Purpose: port assertions of the line-cycle energy block
// Assumes: one clock, synchronous active-high reset
// Notes:   bind follows the module
`timescale 1ns/100ps
module line_cycle_checker (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        half_cycle_mark,
  input wire logic        calibration_pulse_out,
  input wire logic        irq_n,
  input wire logic        irq_oe
);
  logic rd_take;
  logic wr_dp_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  // high during the data phase of a write
  always_ff @(posedge clock) begin
    wr_dp_q <= !sys_rst && hsel && htrans[1] && hready && hwrite;
  end
  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_ready;
    !$past(sys_rst) |-> hreadyout;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
  property p_reset;
    disable iff (1'b0) sys_rst |=> !hreadyout && irq_n && !irq_oe &&
      !calibration_pulse_out && hrdata == 32'h0000_0000;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset outputs");
  property p_oe;
    irq_oe == !irq_n;
  endproperty
  a_oe: assert property (p_oe) else $error("irq enable mismatch");
  property p_irq_fall;
    $fell(irq_n) |-> $past(half_cycle_mark, 2) || $past(wr_dp_q, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("stray irq");
  property p_irq_rise;
    $rose(irq_n) |-> $past(wr_dp_q, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq lost");
  property p_unmapped;
    rd_take && haddr[7:0] >= 8'h30 |=> hrdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not 0");
  property p_hold;
    !$past(rd_take) && !$past(sys_rst) |-> $stable(hrdata);
  endproperty
  a_hold: assert property (p_hold) else $error("hrdata moved");
  property p_width;
    $rose(calibration_pulse_out) |->
      calibration_pulse_out[*8] ##1 calibration_pulse_out
      ##1 calibration_pulse_out;
  endproperty
  a_width: assert property (p_width) else $error("pulse too short");
endmodule : line_cycle_checker

bind line_cycle_energy_gain_cal line_cycle_checker i_line_cycle_checker (
  .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .half_cycle_mark(half_cycle_mark), .irq_n(irq_n), .irq_oe(irq_oe),
  .calibration_pulse_out(calibration_pulse_out)
);

// ===== sim/line_source.sv
// Purpose: line-side source of power samples and zero-crossing marks
// Assumes: one sample every four clocks, marks every gap clocks
// Notes:   sample lines show the inverse between samples
`timescale 1ns/100ps
module line_source (
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire logic signed [15:0] amp,
  input  wire logic [15:0]        appar,
  input  wire logic [15:0]        gap,
  output logic                    sample_valid,
  output logic signed [15:0]      active_sample,
  output logic [15:0]             apparent_sample,
  output logic                    half_cycle_mark
);
  logic [1:0]  phase_q;
  logic [15:0] mark_q;
  // free-running sample phase and mark spacing
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      phase_q <= 2'h0;
      mark_q  <= 16'h0000;
    end else begin
      phase_q <= phase_q + 2'h1;
      mark_q  <= (mark_q == gap - 16'h0001) ? 16'h0000 : mark_q + 16'h0001;
    end
  end
  // stale values never linger on the sample lines
  assign sample_valid    = !sys_rst && phase_q == 2'h0;
  assign active_sample   = sample_valid ? amp : ~amp;
  assign apparent_sample = sample_valid ? appar : ~appar;
  assign half_cycle_mark = !sys_rst && mark_q == 16'h0000;
endmodule : line_source

// ===== sim/tb_top.sv
// Purpose: bench of the line-cycle energy block
// Assumes: marks every GAP clocks
// Notes:   reads checked from a queue
`timescale 1ns/100ps
module tb_top;
  import energy_cal_pkg::*;
  localparam int GAP = 200;
  localparam int SPI = 200; // samples per interval
  typedef struct { logic [31:0] v; int tol; string name; } exp_s;
  logic clock, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic sample_valid, half_cycle_mark, calibration_pulse_out, irq_n, irq_oe;
  logic signed [15:0] active_sample, amp;
  logic [15:0] apparent_sample, appar, gap;
  logic dp_rd_q, pulse_prev;
  exp_s exp_q[$];
  exp_s cur;
  int bad_count, check_count, pulse_count;
  logic [7:0] ra [8] = '{OFS_CONTROL, OFS_FINE_GAIN, OFS_ENERGY_DIV,
    OFS_PULSE_NUM, OFS_PULSE_DEN, OFS_HALF_CYCLES, OFS_IRQ_MASK, 8'h30};
  logic [31:0] rv [8] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'(RST_PULSE_NUM), 32'(RST_PULSE_DEN), 32'(RST_HALF_CYCLES),
    32'h0000_0000, 32'h0000_0000};
  assign hready = hreadyout;
  line_cycle_energy_gain_cal i_line_cycle_energy_gain_cal (
    .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sample_valid(sample_valid),
    .active_sample(active_sample), .apparent_sample(apparent_sample),
    .half_cycle_mark(half_cycle_mark), .irq_n(irq_n), .irq_oe(irq_oe),
    .calibration_pulse_out(calibration_pulse_out));
  line_source i_line_source (
    .clock(clock), .sys_rst(sys_rst), .amp(amp), .appar(appar), .gap(gap),
    .sample_valid(sample_valid), .active_sample(active_sample),
    .apparent_sample(apparent_sample), .half_cycle_mark(half_cycle_mark));
  // ---------------------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, logic [31:0] e, s, int tol);
    logic signed [32:0] d;
    d = $signed({s[31], s}) - $signed({e[31], e});
    check_count++;
    if ((^s === 1'bx) || d > tol || d < -tol) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (bad_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // read data monitor takes the oldest note at each data-phase end
  always @(posedge clock) begin
    if (dp_rd_q && exp_q.size() > 0) begin
      cur = exp_q.pop_front();
      chk(cur.name, cur.v, hrdata, cur.tol);
    end
    dp_rd_q <= hsel && htrans[1] && hready && !hwrite;
  end
  // counts pulse starts
  always @(negedge clock) begin
    pulse_prev <= calibration_pulse_out;
    if (calibration_pulse_out === 1'b1 && pulse_prev === 1'b0) begin
      pulse_count++;
    end
  end
  // ---------------------------------------------------------------------------
  // bus and sequence tasks
  // ---------------------------------------------------------------------------
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
  endtask : bus
  task automatic rd(input logic [7:0] a, string nm, logic [31:0] e,
                    int tol);
    exp_q.push_back('{e, tol, nm});
    bus(a, 1'b0, 32'h0000_0000);
  endtask : rd
  task automatic wait_irq();
    int n;
    n = 0;
    repeat (2) @(negedge clock);
    while (irq_n !== 1'b0 && n < 5000) begin
      @(negedge clock);
      n++;
    end
    chk("irq_n", 32'h0000_0000, {31'h0, irq_n}, 0);
  endtask : wait_irq
  task automatic run_case(input int a, g, dv, nu, de, ap);
    int s, t, ex;
    s = (a * (4096 + g)) >>> 12;
    t = (SPI * (s < 0 ? -s : s)) >>> FRAC_BITS;
    ex = (s < 0 ? -t : t) / (dv == 0 ? 1 : dv);
    amp   <= a[15:0];
    appar <= ap[15:0];
    bus(OFS_PULSE_DEN, 1'b1, 32'(de));
    bus(OFS_PULSE_NUM, 1'b1, 32'(nu));
    bus(OFS_FINE_GAIN, 1'b1, 32'(g) & 32'h0000_0FFF);
    bus(OFS_ENERGY_DIV, 1'b1, 32'(dv));
    bus(OFS_CONTROL, 1'b1, 32'h0000_0001);
    bus(OFS_IRQ_MASK, 1'b1, 32'h0000_0000);
    bus(OFS_HALF_CYCLES, 1'b1, 32'h0000_0004);
    bus(OFS_IRQ_STATUS, 1'b1, 32'h0000_0003);
    repeat (1000) @(negedge clock);
    chk("irq masked", 32'h0000_0001, {31'h0, irq_n}, 0);
    bus(OFS_IRQ_MASK, 1'b1, 32'h0000_0001);
    wait_irq();
    bus(OFS_IRQ_STATUS, 1'b1, 32'h0000_0003);
    wait_irq();
    bus(OFS_IRQ_STATUS, 1'b1, 32'h0000_0003);
    pulse_count = 0;
    wait_irq();
    chk("pulses", 32'(t * (nu + 1) / (de + 1)), 32'(pulse_count), 1);
    rd(OFS_LINE_ACTIVE, "line active", 32'(ex), 1);
    rd(OFS_LINE_APPAR, "line apparent", 32'((SPI * ap) >>> 16), 1);
    rd(OFS_LINE_PERIOD, "period", 32'(2 * GAP / PERIOD_PRESCALE), 1);
    bus(OFS_LINE_ACTIVE, 1'b1, 32'h0000_0123);
    rd(OFS_LINE_ACTIVE, "read only", 32'(ex), 1);
    bus(OFS_IRQ_STATUS, 1'b1, 32'h0000_0003);
    wait_irq();
    rd(OFS_LINE_ACTIVE, "next interval", 32'(ex), 1);
  endtask : run_case
  // ---------------------------------------------------------------------------
  // clock, watchdog and main sequence
  // ---------------------------------------------------------------------------
  always #50 clock = ~clock;
  initial begin
    #(100 * 40000);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    clock   = 1'b0;
    sys_rst = 1'b1;
    hsel    = 1'b0;
    haddr   = 32'h0000_0000;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'b010;
    hwdata  = 32'h0000_0000;
    amp     = 16'h0000;
    appar   = 16'h0000;
    gap     = 16'(GAP);
    dp_rd_q = 1'b0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    void'($urandom(14627));
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], "reset value", rv[i], 0);
    end
    run_case(16384, 0, 0, 0, 4, 8192);
    run_case(16384, 2047, 2, 1, 4, 4096);
    run_case(-16384, -2048, 0, 0, 1, 0);
    run_case(int'($urandom_range(16383, 8192)),
             int'($urandom_range(4095)) - 2048, 1, 0, 3,
             int'($urandom_range(16383)));
    tally_and_finish();
  end
endmodule : tb_top
